/* src/ehpw_pkg.sv */
// Constants for the host-port simplex write master.
`default_nettype none
package ehpw_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CNT_W = 6;

    // ------------------------------------------------------------
    // Phase lengths in expansion-bus clock cycles
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] SEL_TO_STROBE_CYC = 6'h03;
    localparam logic [CNT_W-1:0] STROBE_CYC = 6'h04;
    localparam logic [CNT_W-1:0] HOLD_CYC = 6'h04;
    localparam logic [CNT_W-1:0] RECOV_CYC = 6'h02;
    localparam logic [CNT_W-1:0] ADDR_MIN_CYC = 6'h0b;

    // ------------------------------------------------------------
    // Bus mode of the selected chip select
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_STROBE = 2'h0;
    localparam logic [1:0] MODE_RWSEL = 2'h1;
    localparam logic [1:0] MODE_HOST_PORT = 2'h2;

    // Access states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_RECOV = 5'b10000
    } ehpw_state_t;
endpackage
`default_nettype wire

/* src/ehpw_phase_cnt.sv */
// Down counter that times one access phase.
`timescale 1ns/1ps
`default_nettype none
module ehpw_phase_cnt
    import ehpw_pkg::*;
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Control.
    input wire logic i_load,
    input wire logic [CNT_W-1:0] i_load_val,
    input wire logic i_stall,
    // Status.
    output logic o_last,
    output logic [CNT_W-1:0] o_cnt
);
    logic [CNT_W-1:0] cnt_r;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // One step per bus clock; a stall freezes the count.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_load_val;
        end else if (!i_stall && cnt_r != '0) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end

    assign o_last = (cnt_r == 6'h01) && !i_stall;
    assign o_cnt = cnt_r;
endmodule
`default_nettype wire

/* src/ehpw_host_write.sv */
// Expansion-bus master for 16-bit host-port simplex writes.
// Function
// - Address valid with select, 11 to 45
// - Strobe 3 to 4 cycles after select
// - Strobe pulse width 4 to 5 cycles
// - Data valid 4 to 5 before strobe rise
// - Data held 4 to 36 after rise
// - Recovery 2 to 17 cycles between accesses
// - Hold setup one clock after ready deasserts
// - All counts in expansion-bus clock cycles
// - Wait shared on selects 0-7, strobe/rwsel only
// - Ignore wait on synchronous strobe-mode writes
`timescale 1ns/1ps
`default_nettype none
module ehpw_host_write
    import ehpw_pkg::*;
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Write request.
    input wire logic i_wr_req,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic [2:0] i_wr_cs,
    input wire logic [1:0] i_bus_mode,
    input wire logic i_sync_write,
    // Configuration.
    input wire logic i_ready_en,
    // Slave handshakes.
    input wire logic i_host_ready_indicator,
    input wire logic i_ext_wait_request_n,
    // Bus pins.
    output logic [ADDR_W-1:0] o_addr,
    output logic [7:0] o_cs_n,
    output logic o_host_data_strobe_n,
    output logic [DATA_W-1:0] o_data,
    output logic o_data_oe,
    // Status.
    output logic o_busy,
    output logic o_done
);
    ehpw_state_t state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_r;
    logic [2:0] cs_r;
    logic wait_honoured_r;
    logic ready_busy_r;
    logic cnt_load, cnt_stall, cnt_last, take;
    logic [CNT_W-1:0] cnt_val, cnt_now;
    logic [7:0] cs_n_r;
    logic strobe_n_r, oe_r, busy_r, done_r;

    // Decodes a select number into an active-low select vector.
    function automatic logic [7:0] cs_decode_n(input logic [2:0] sel);
        cs_decode_n = ~(8'h01 << sel);
    endfunction

    // Tells whether a state holds the select active.
    function automatic logic cs_phase(input ehpw_state_t st);
        cs_phase = (st == ST_SETUP) || (st == ST_STROBE) || (st == ST_HOLD);
    endfunction

    // ------------------------------------------------------------
    // Phase control
    // ------------------------------------------------------------
    // A new request is taken when idle or on the last recovery cycle.
    assign take = i_wr_req && ((state_r == ST_IDLE) || (state_r == ST_RECOV && cnt_last));

    // Setup waits while the slave is busy and one clock more.
    // Strobe waits on a low wait request only when honoured.
    always_comb begin
        cnt_stall = 1'b0;
        if (state_r == ST_SETUP) begin
            cnt_stall = i_ready_en && (i_host_ready_indicator || ready_busy_r);
        end else if (state_r == ST_STROBE) begin
            cnt_stall = wait_honoured_r && !i_ext_wait_request_n;
        end
    end

    // Next state and counter reload.
    always_comb begin
        state_nxt = state_r;
        cnt_load = 1'b0;
        cnt_val = '0;
        unique case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_SETUP;
                    cnt_load = 1'b1;
                    cnt_val = SEL_TO_STROBE_CYC;
                end
            end
            ST_SETUP: begin
                if (cnt_last) begin
                    state_nxt = ST_STROBE;
                    cnt_load = 1'b1;
                    cnt_val = STROBE_CYC;
                end
            end
            ST_STROBE: begin
                if (cnt_last) begin
                    state_nxt = ST_HOLD;
                    cnt_load = 1'b1;
                    cnt_val = HOLD_CYC;
                end
            end
            ST_HOLD: begin
                if (cnt_last) begin
                    state_nxt = ST_RECOV;
                    cnt_load = 1'b1;
                    cnt_val = RECOV_CYC;
                end
            end
            ST_RECOV: begin
                if (take) begin
                    state_nxt = ST_SETUP;
                    cnt_load = 1'b1;
                    cnt_val = SEL_TO_STROBE_CYC;
                end else if (cnt_last) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    ehpw_phase_cnt u_cnt (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_load(cnt_load),
        .i_load_val(cnt_val),
        .i_stall(cnt_stall),
        .o_last(cnt_last),
        .o_cnt(cnt_now)
    );

    // State register.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Remembers a busy slave for one extra setup clock.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ready_busy_r <= 1'b0;
        end else begin
            ready_busy_r <= i_ready_en && i_host_ready_indicator;
        end
    end

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    // Address, data and select stay frozen for the whole access.
    // The wait request is honoured only in strobe or rwsel mode, and
    // never on a synchronous strobe-mode write.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_r <= '0;
            data_r <= '0;
            cs_r <= '0;
            wait_honoured_r <= 1'b0;
        end else if (take) begin
            addr_r <= i_wr_addr;
            data_r <= i_wr_data;
            cs_r <= i_wr_cs;
            wait_honoured_r <= (i_bus_mode == MODE_RWSEL) ||
                ((i_bus_mode == MODE_STROBE) && !i_sync_write);
        end
    end

    // ------------------------------------------------------------
    // Registered pin drive
    // ------------------------------------------------------------
    // Select, strobe, enable and busy are decoded from the next state, done from the current one; each comes from a flop.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cs_n_r <= 8'hff;
            strobe_n_r <= 1'b1;
            oe_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cs_n_r <= cs_phase(state_nxt) ? cs_decode_n(take ? i_wr_cs : cs_r) : 8'hff;
            strobe_n_r <= (state_nxt != ST_STROBE);
            oe_r <= (state_nxt == ST_STROBE) || (state_nxt == ST_HOLD);
            busy_r <= (state_nxt != ST_IDLE);
            done_r <= (state_r == ST_HOLD) && cnt_last;
        end
    end

    assign o_addr = addr_r;
    assign o_data = data_r;
    assign o_cs_n = cs_n_r;
    assign o_host_data_strobe_n = strobe_n_r;
    assign o_data_oe = oe_r;
    assign o_busy = busy_r;
    assign o_done = done_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic cs_act;
    logic [CNT_W-1:0] cs_len_r;
    assign cs_act = (cs_n_r != 8'hff);

    // Counts how long the select has been active, saturating.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cs_len_r <= '0;
        end else if (!cs_act) begin
            cs_len_r <= '0;
        end else if (cs_len_r != 6'h3f) begin
            cs_len_r <= cs_len_r + 6'h01;
        end
    end

    sequence s_strobe_pulse;
        !strobe_n_r [*4] ##1 strobe_n_r;
    endsequence

    sequence s_sel_lead;
        strobe_n_r [*3] ##1 !strobe_n_r;
    endsequence

    property p_addr_len;
        @(posedge i_mclk) disable iff (!i_nrst)
        $fell(cs_act) |-> cs_len_r >= ADDR_MIN_CYC && $stable(o_addr);
    endproperty
    a_addr_len: assert property (p_addr_len) else $error("select shorter than 11 cycles");

    property p_sel_to_strobe;
        @(posedge i_mclk) disable iff (!i_nrst)
        ($rose(cs_act) && !i_ready_en) |-> s_sel_lead;
    endproperty
    a_sel_to_strobe: assert property (p_sel_to_strobe) else $error("strobe lead wrong");

    property p_strobe_width;
        @(posedge i_mclk) disable iff (!i_nrst)
        ($fell(strobe_n_r) && !wait_honoured_r) |-> s_strobe_pulse;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

    property p_data_setup;
        @(posedge i_mclk) disable iff (!i_nrst)
        ($rose(strobe_n_r) && !wait_honoured_r) |-> $past(oe_r, 4) && !$past(oe_r, 5);
    endproperty
    a_data_setup: assert property (p_data_setup) else $error("data setup wrong");

    property p_data_hold;
        @(posedge i_mclk) disable iff (!i_nrst)
        $rose(strobe_n_r) |-> oe_r [*4] ##1 !oe_r;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data hold wrong");

    property p_recovery;
        @(posedge i_mclk) disable iff (!i_nrst)
        $fell(cs_act) |-> !cs_act [*2];
    endproperty
    a_recovery: assert property (p_recovery) else $error("recovery too short");

    property p_ready_hold;
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_r == ST_SETUP && i_ready_en && i_host_ready_indicator)
            |=> (state_r == ST_SETUP) ##1 (state_r == ST_SETUP);
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("setup left too early");

    property p_wait_ignored;
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_r == ST_STROBE && !wait_honoured_r)
            |=> (state_r == ST_HOLD) || (cnt_now == $past(cnt_now) - 6'h01);
    endproperty
    a_wait_ignored: assert property (p_wait_ignored) else $error("wait not ignored");

    property p_wait_extends;
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_r == ST_STROBE && wait_honoured_r && !i_ext_wait_request_n)
            |=> (state_r == ST_STROBE) && !strobe_n_r && $stable(cnt_now);
    endproperty
    a_wait_extends: assert property (p_wait_extends) else $error("wait did not stretch");
endmodule
`default_nettype wire

/* testbench/ehpw_slave_model.sv */
// Behavioural slave with a 16-bit host port for the simplex write master.
`timescale 1ns/1ps
`default_nettype none
module ehpw_slave_model
    import ehpw_pkg::*;
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Bus pins from the master.
    input wire logic [7:0] i_cs_n,
    input wire logic i_host_data_strobe_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic i_data_oe,
    // Slowness set by the bench.
    input wire logic [3:0] i_rdy_len,
    input wire logic [3:0] i_wait_len,
    // Handshakes back to the master.
    output logic o_host_ready_indicator,
    output logic o_ext_wait_request_n,
    // Last word written.
    output logic [ADDR_W-1:0] o_cap_addr,
    output logic [DATA_W-1:0] o_cap_data
);
    logic cs_q;
    logic st_q;
    logic [3:0] rdy_cnt;
    logic [3:0] wait_cnt;

    // Responds just after each edge, so the master sees stable handshakes at the next one.
    initial begin
        cs_q = 1'b0;
        st_q = 1'b1;
        rdy_cnt = 4'h0;
        wait_cnt = 4'h0;
        o_cap_addr = '0;
        o_cap_data = '0;
        o_host_ready_indicator = 1'b0;
        o_ext_wait_request_n = 1'b1;
        forever begin
            @(posedge i_mclk);
            #1;
            if (i_nrst && i_cs_n !== 8'hff && !cs_q) begin
                rdy_cnt = i_rdy_len;
            end
            if (i_nrst && i_host_data_strobe_n === 1'b0 && st_q) begin
                wait_cnt = i_wait_len;
            end
            // Data is taken at the strobe rise, when it must still be driven.
            if (i_host_data_strobe_n === 1'b1 && !st_q && i_data_oe === 1'b1) begin
                o_cap_addr = i_addr;
                o_cap_data = i_data;
            end
            o_host_ready_indicator = (rdy_cnt != 4'h0);
            // The shared wait line is only pulled low while this slave is selected.
            o_ext_wait_request_n = !(wait_cnt != 4'h0 && i_cs_n !== 8'hff);
            if (rdy_cnt != 4'h0) rdy_cnt = rdy_cnt - 4'h1;
            if (wait_cnt != 4'h0) wait_cnt = wait_cnt - 4'h1;
            cs_q = (i_cs_n !== 8'hff);
            st_q = (i_host_data_strobe_n !== 1'b0);
        end
    end
endmodule
`default_nettype wire

/* testbench/expansion_bus_host_port_write_tb.sv */
// Self-checking bench for the host-port simplex write master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module expansion_bus_host_port_write_tb;
    import ehpw_pkg::*;
    logic i_mclk, i_nrst, i_wr_req, i_sync_write, i_ready_en;
    logic [ADDR_W-1:0] i_wr_addr;
    logic [DATA_W-1:0] i_wr_data;
    logic [2:0] i_wr_cs;
    logic [1:0] i_bus_mode;
    logic [3:0] rdy_len, wait_len;
    wire logic i_host_ready_indicator, i_ext_wait_request_n, o_host_data_strobe_n;
    wire logic o_data_oe, o_busy, o_done;
    wire logic [ADDR_W-1:0] o_addr, cap_addr;
    wire logic [DATA_W-1:0] o_data, cap_data;
    wire logic [7:0] o_cs_n;
    int fails, tests_run, k;
    int cs_len, pre, st, oe_st, post, gap, starts, dones;
    int m_cs, m_pre, m_st, m_oest, m_post, m_gap;
    logic [7:0] m_csv, cs_cur;
    logic prev_cs;

    ehpw_host_write dut_u (.i_mclk, .i_nrst, .i_wr_req, .i_wr_addr, .i_wr_data, .i_wr_cs,
        .i_bus_mode, .i_sync_write, .i_ready_en, .i_host_ready_indicator,
        .i_ext_wait_request_n, .o_addr, .o_cs_n, .o_host_data_strobe_n, .o_data, .o_data_oe,
        .o_busy, .o_done);
    ehpw_slave_model slave_u (.i_mclk, .i_nrst, .i_cs_n(o_cs_n),
        .i_host_data_strobe_n(o_host_data_strobe_n), .i_addr(o_addr), .i_data(o_data),
        .i_data_oe(o_data_oe), .i_rdy_len(rdy_len), .i_wait_len(wait_len),
        .o_host_ready_indicator(i_host_ready_indicator),
        .o_ext_wait_request_n(i_ext_wait_request_n), .o_cap_addr(cap_addr),
        .o_cap_data(cap_data));

    // Free-running bus clock at 25 MHz.
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    // Phase monitor on the falling edge, where every registered output has settled.
    always @(negedge i_mclk) begin
        if (o_done === 1'b1) dones++;
        if (o_cs_n !== 8'hff) begin
            if (!prev_cs) begin
                starts++;
                m_gap = gap;
                cs_cur = o_cs_n;
                cs_len = 0; pre = 0; st = 0; oe_st = 0; post = 0;
            end
            cs_len++;
            if (o_host_data_strobe_n === 1'b0) begin
                st++;
                if (o_data_oe === 1'b1) oe_st++;
            end else if (st == 0) pre++;
            else if (o_data_oe === 1'b1) post++;
            prev_cs = 1'b1;
        end else begin
            if (prev_cs) begin
                m_cs = cs_len; m_pre = pre; m_st = st; m_oest = oe_st; m_post = post; gap = 0;
                // The select is latched at the end so a queued follower cannot overwrite it.
                m_csv = cs_cur;
            end
            gap++;
            prev_cs = 1'b0;
        end
    end

    // Presents one request and holds it until the access starts; hold keeps it up for a follower.
    task automatic wr(input logic [2:0] c, input logic [1:0] m, input logic s, input bit hold);
        int n0;
        n0 = starts;
        @(posedge i_mclk);
        #1;
        i_wr_req = 1'b1; i_wr_cs = c; i_bus_mode = m; i_sync_write = s;
        i_wr_addr = 24'h5a0300 + c; i_wr_data = 16'hc3a0 + {m, s, c};
        for (k = 0; k < 100 && starts == n0; k++) @(posedge i_mclk);
        if (k == 100) fails++;
        #1;
        if (!hold) i_wr_req = 1'b0;
    endtask

    // Waits, bounded, until the master has left recovery.
    task automatic idle_wait();
        for (k = 0; k < 200 && o_busy !== 1'b0; k++) begin
            @(posedge i_mclk);
            #1;
        end
        if (k == 200) fails++;
    endtask

    // Compares the last finished access; ep or es below zero means a stretched phase.
    task automatic acc_chk(input logic [2:0] c, input logic [1:0] m, input logic s,
        input int ep, input int es);
        `CHK("select", ~(8'h01 << c), m_csv)
        `CHK("addr_window", 1'b1, m_cs >= 11 && m_cs <= 45)
        if (ep >= 0 && es >= 0) `CHK("addr_len", 11, m_cs)
        if (ep >= 0) `CHK("sel_to_strobe", ep, m_pre)
        else `CHK("setup_held", 1'b1, m_pre > 3)
        if (es >= 0) `CHK("strobe_width", es, m_st)
        else `CHK("strobe_stretch", 1'b1, m_st > 4)
        `CHK("setup_min", 1'b1, m_pre >= 2)
        `CHK("strobe_min", 1'b1, m_st >= 1)
        `CHK("data_before_rise", m_st, m_oest)
        `CHK("data_hold", 4, m_post)
        `CHK("addr_seen", 24'h5a0300 + c, cap_addr)
        `CHK("data_seen", 16'hc3a0 + {m, s, c}, cap_data)
    endtask

    task automatic finish_test();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog sized well above the ten accesses of the sequence.
    initial begin
        repeat (5000) @(posedge i_mclk);
        fails++;
        finish_test();
    end

    // Main sequence.
    initial begin
        fails = 0; tests_run = 0; starts = 0; dones = 0; gap = 0; prev_cs = 1'b0;
        i_nrst = 1'b0; i_wr_req = 1'b0; i_sync_write = 1'b0; i_ready_en = 1'b0;
        i_wr_addr = '0; i_wr_data = '0; i_wr_cs = 3'h0; i_bus_mode = MODE_STROBE;
        rdy_len = 4'h0; wait_len = 4'h0;
        repeat (16) @(posedge i_mclk);
        `CHK("reset_pins", 11'h7fc, {o_cs_n, o_host_data_strobe_n, o_data_oe, o_busy})
        `CHK("reset_done", 1'b0, o_done)
        #1 i_nrst = 1'b1;
        // Wait line held low in every mode, with and without synchronous writes.
        wait_len = 4'h3;
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr(3'(m * 2 + s), 2'(m), 1'(s), 1'b0);
                idle_wait();
                acc_chk(3'(m * 2 + s), 2'(m), 1'(s), 3, (m == 2 || (m == 0 && s == 1)) ? 4 : -1);
            end
        end
        // Busy slave through the ready indicator, then the same slave with it disabled.
        wait_len = 4'h0; rdy_len = 4'h2; i_ready_en = 1'b1;
        wr(3'h3, MODE_HOST_PORT, 1'b0, 1'b0);
        idle_wait();
        acc_chk(3'h3, MODE_HOST_PORT, 1'b0, -1, 4);
        i_ready_en = 1'b0;
        wr(3'h4, MODE_HOST_PORT, 1'b0, 1'b0);
        idle_wait();
        acc_chk(3'h4, MODE_HOST_PORT, 1'b0, 3, 4);
        // Back-to-back accesses on the two top selects.
        rdy_len = 4'h0;
        wr(3'h7, MODE_HOST_PORT, 1'b0, 1'b1);
        wr(3'h6, MODE_HOST_PORT, 1'b0, 1'b0);
        `CHK("recovery_gap", 2, m_gap)
        acc_chk(3'h7, MODE_HOST_PORT, 1'b0, 3, 4);
        idle_wait();
        acc_chk(3'h6, MODE_HOST_PORT, 1'b0, 3, 4);
        repeat (2) @(posedge i_mclk);
        `CHK("done_pulses", 10, dones)
        finish_test();
    end
endmodule
`default_nettype wire
